// *** pkg/dma_channel_defs.svh ***
// register offsets, field positions, reset values and bit layouts of the dma channel
// Notes on behaviour
// - bit 14 set means byte transfers, clear means 16-bit word transfers.
// - bit 13 set reads RAM and writes the peripheral, clear reads peripheral and writes RAM.
// - bit 12 set raises the block interrupt at half the block, clear at the whole block.
// - null_write_mode adds a null peripheral write per element; software keeps bit 13 clear.
// - addressing 10 is peripheral indirect, 01 register indirect without increment, 11 reserved.
// - operating mode 00/10 is continuous, 01/11 one-shot; the upper bit enables ping-pong.
// - one-shot with ping-pong does one block with each of the two buffers and then stops.
`ifndef DMA_CHANNEL_DEFS_SVH
`define DMA_CHANNEL_DEFS_SVH
`define OFS_CONTROL 12'h000
`define OFS_RAM_ADDR_A 12'h004
`define OFS_RAM_ADDR_B 12'h008
`define OFS_PER_ADDR 12'h00C
`define OFS_COUNT 12'h010
`define OFS_STATUS 12'h014
`define OFS_IRQ_EN 12'h018
`define OFS_IRQ_CLR 12'h01C
`define OFS_REQUEST 12'h020
`define BIT_ENABLE 15
`define BIT_SIZE 14
`define BIT_DIR 13
`define BIT_HALF 12
`define BIT_NULL_WRITE 11
`define BIT_ADDR_MODE_HI 5
`define BIT_ADDR_MODE_LO 4
`define BIT_MODE_HI 1
`define BIT_MODE_LO 0
`define CONTROL_WMASK 16'hF833
`define CONTROL_RESET 16'h0000
`define ADDR_RESET 16'h0000
`define COUNT_RESET 16'h0000
`define ST_BLOCK 0
`define ST_HALF 1
`define ST_PINGPONG 2
`define ST_BUSY 3
`define ST_BUFFER 4
`define NULL_VALUE 16'h0000
`endif

// *** pkg/dma_channel_pkg.sv ***
// types shared by the dma channel files
package dma_channel_pkg;
  typedef enum logic [1:0] {AM_POST_INC, AM_REG_IND, AM_PERIPH_IND, AM_RESERVED} addr_mode_t;
  typedef enum {S_IDLE, S_READ, S_WRITE, S_NULL_WRITE} xfer_state_t;
endpackage

// *** src/dma_bus_mover.sv ***
// one element mover: read source, write destination, optional null write
`timescale 1ns/1ps
`include "dma_channel_defs.svh"
module dma_bus_mover
  import dma_channel_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic byte_mode,
  input wire logic ram_to_periph,
  input wire logic null_write,
  input wire logic [15:0] ram_addr,
  input wire logic [15:0] per_addr,
  output logic bus_req,
  output logic bus_we,
  output logic bus_byte,
  output logic [15:0] bus_addr,
  output logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic bus_ack,
  output logic done
);
  xfer_state_t state_r;
  logic [15:0] data_r;
  // one element per start; the read and write sides follow the direction bit
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= S_IDLE;
      data_r <= 16'h0000;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state_r)
        S_IDLE:
          if (start)
            state_r <= S_READ;
        S_READ:
          if (bus_ack)
          begin
            data_r <= byte_mode ? {8'h00, bus_rdata[7:0]} : bus_rdata;
            state_r <= S_WRITE;
          end
        S_WRITE:
          if (bus_ack)
          begin
            // null write only makes sense reading the peripheral
            if (null_write && !ram_to_periph)
              state_r <= S_NULL_WRITE;
            else
            begin
              state_r <= S_IDLE;
              done <= 1'b1;
            end
          end
        S_NULL_WRITE:
          if (bus_ack)
          begin
            state_r <= S_IDLE;
            done <= 1'b1;
          end
        default:
          state_r <= S_IDLE;
      endcase
    end
  end
  // bus request decode, combinational handshake
  always_comb
  begin
    bus_req = (state_r == S_READ) || (state_r == S_WRITE) || (state_r == S_NULL_WRITE);
    bus_we = (state_r != S_READ);
    bus_byte = byte_mode;
    bus_wdata = (state_r == S_NULL_WRITE) ? `NULL_VALUE : data_r;
    case (state_r)
      S_READ: bus_addr = ram_to_periph ? ram_addr : per_addr;
      S_WRITE: bus_addr = ram_to_periph ? per_addr : ram_addr;
      S_NULL_WRITE: bus_addr = per_addr;
      default: bus_addr = 16'h0000;
    endcase
  end
endmodule // dma_bus_mover

// *** src/dma_channel_control.sv ***
// one dma channel: apb registers, block sequencing, ping-pong and interrupts
`timescale 1ns/1ps
`include "dma_channel_defs.svh"
module dma_channel_control
  import dma_channel_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic PERIPH_REQ,
  output logic BUS_REQ,
  output logic BUS_WE,
  output logic BUS_BYTE,
  output logic [15:0] BUS_ADDR,
  output logic [15:0] BUS_WDATA,
  input wire logic [15:0] BUS_RDATA,
  input wire logic BUS_ACK,
  output logic IRQ
);
  logic [15:0] control_r;
  logic [15:0] ram_a_r;
  logic [15:0] ram_b_r;
  logic [15:0] per_addr_r;
  logic [15:0] count_r;
  logic [15:0] xfer_idx_r;
  logic [15:0] ram_off_r;
  logic buf_sel_r;
  logic busy_r;
  logic [2:0] status_r;
  logic [2:0] irq_en_r;
  logic soft_req_r;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic mover_done;
  logic start;
  logic block_end;
  logic half_hit;
  logic [2:0] ev;
  logic [15:0] ram_addr;
  logic [15:0] last_idx;
  logic chan_en;
  logic byte_mode;
  logic dir_r2p;
  logic half_sel;
  logic null_write_mode;
  addr_mode_t addressing_mode_select;
  logic one_shot;
  logic ping_pong;

  // control field decode
  assign chan_en = control_r[`BIT_ENABLE];
  assign byte_mode = control_r[`BIT_SIZE];
  assign dir_r2p = control_r[`BIT_DIR];
  assign half_sel = control_r[`BIT_HALF];
  assign null_write_mode = control_r[`BIT_NULL_WRITE];
  assign addressing_mode_select = addr_mode_t'(control_r[`BIT_ADDR_MODE_HI:`BIT_ADDR_MODE_LO]);
  assign one_shot = control_r[`BIT_MODE_LO];
  assign ping_pong = control_r[`BIT_MODE_HI];

  // apb decode; zero wait states, unmapped addresses answer with an error
  assign PREADY = 1'b1;
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && !PWRITE;
  always_comb
  begin
    case (PADDR)
      `OFS_CONTROL, `OFS_RAM_ADDR_A, `OFS_RAM_ADDR_B, `OFS_PER_ADDR, `OFS_COUNT,
      `OFS_STATUS, `OFS_IRQ_EN, `OFS_IRQ_CLR, `OFS_REQUEST: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign PSLVERR = PSEL && PENABLE && !addr_ok;

  // read data registered in the setup phase so it is stable in the access phase
  always_ff @(posedge CLK)
  begin
    if (RST)
      PRDATA <= 32'h0000_0000;
    else if (rd_en && !PENABLE)
    begin
      case (PADDR)
        `OFS_CONTROL: PRDATA <= {16'h0000, control_r};
        `OFS_RAM_ADDR_A: PRDATA <= {16'h0000, ram_a_r};
        `OFS_RAM_ADDR_B: PRDATA <= {16'h0000, ram_b_r};
        `OFS_PER_ADDR: PRDATA <= {16'h0000, per_addr_r};
        `OFS_COUNT: PRDATA <= {16'h0000, count_r};
        `OFS_STATUS: PRDATA <= {27'h0, buf_sel_r, busy_r, status_r};
        `OFS_IRQ_EN: PRDATA <= {29'h0, irq_en_r};
        default: PRDATA <= 32'h0000_0000;
      endcase
    end
  end

  // configuration registers; reserved control bits stay zero
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      control_r <= `CONTROL_RESET;
      ram_a_r <= `ADDR_RESET;
      ram_b_r <= `ADDR_RESET;
      per_addr_r <= `ADDR_RESET;
      count_r <= `COUNT_RESET;
      irq_en_r <= 3'h0;
    end
    else
    begin
      if (wr_en && PADDR == `OFS_CONTROL)
        control_r <= PWDATA[15:0] & `CONTROL_WMASK;
      // stop on the very edge that ends the last block, so a request that is
      // still held high cannot slip one more element in before the enable drops
      else if (block_end && one_shot && ping_pong && buf_sel_r)
        control_r[`BIT_ENABLE] <= 1'b0;
      else if (block_end && one_shot && !ping_pong)
        control_r[`BIT_ENABLE] <= 1'b0;
      if (wr_en && PADDR == `OFS_RAM_ADDR_A)
        ram_a_r <= PWDATA[15:0];
      if (wr_en && PADDR == `OFS_RAM_ADDR_B)
        ram_b_r <= PWDATA[15:0];
      if (wr_en && PADDR == `OFS_PER_ADDR)
        per_addr_r <= PWDATA[15:0];
      if (wr_en && PADDR == `OFS_COUNT)
        count_r <= PWDATA[15:0];
      if (wr_en && PADDR == `OFS_IRQ_EN)
        irq_en_r <= PWDATA[2:0];
    end
  end

  // software trigger, one pending request held until the mover takes it or the channel is disabled
  always_ff @(posedge CLK)
  begin
    if (RST)
      soft_req_r <= 1'b0;
    else if (wr_en && PADDR == `OFS_REQUEST && PWDATA[0])
      soft_req_r <= 1'b1;
    else if (start || !chan_en)
      soft_req_r <= 1'b0;
  end

  // element start only while enabled and not already moving
  assign start = chan_en && !busy_r && (PERIPH_REQ || soft_req_r);
  assign last_idx = count_r;
  // an element that finishes after a disable counts towards no block
  assign block_end = mover_done && chan_en && (xfer_idx_r == last_idx);
  assign half_hit = mover_done && chan_en && (xfer_idx_r == (last_idx >> 1));

  // ram address: post-increment only in mode 00; 01 keeps the base, 10 adds the peripheral address
  always_comb
  begin
    case (addressing_mode_select)
      AM_POST_INC: ram_addr = (buf_sel_r ? ram_b_r : ram_a_r) + ram_off_r;
      AM_REG_IND: ram_addr = buf_sel_r ? ram_b_r : ram_a_r;
      AM_PERIPH_IND: ram_addr = (buf_sel_r ? ram_b_r : ram_a_r) + per_addr_r;
      default: ram_addr = buf_sel_r ? ram_b_r : ram_a_r; // reserved code, no stepping
    endcase
  end

  // busy follows the mover itself: a disable in mid-element lets that element
  // finish its bus accesses, and no start can reach a mover that is still working
  always_ff @(posedge CLK)
  begin
    if (RST)
      busy_r <= 1'b0;
    else if (start)
      busy_r <= 1'b1;
    else if (mover_done)
      busy_r <= 1'b0;
  end

  // block progress and buffer toggling; a disable rewinds to buffer A
  always_ff @(posedge CLK)
  begin
    if (RST || !chan_en)
    begin
      xfer_idx_r <= 16'h0000;
      ram_off_r <= 16'h0000;
      buf_sel_r <= 1'b0;
    end
    else
    begin
      if (block_end)
      begin
        xfer_idx_r <= 16'h0000;
        ram_off_r <= 16'h0000;
        if (ping_pong)
          buf_sel_r <= !buf_sel_r;
      end
      else if (mover_done)
      begin
        xfer_idx_r <= xfer_idx_r + 16'h0001;
        if (addressing_mode_select == AM_POST_INC)
          ram_off_r <= ram_off_r + (byte_mode ? 16'h0001 : 16'h0002);
      end
    end
  end

  // interrupt events: block done (half done when bit 12 is set), half done, ping-pong pair done
  assign ev[`ST_BLOCK] = half_sel ? half_hit : block_end;
  assign ev[`ST_HALF] = half_hit;
  assign ev[`ST_PINGPONG] = block_end && ping_pong && buf_sel_r;

  // sticky status, one flop per event; a set in the same cycle as a clear wins,
  // so software never loses an event that lands on its own clear
  generate
    for (genvar k = 0; k < 3; k++)
    begin : g_status
      always_ff @(posedge CLK)
      begin
        if (RST)
          status_r[k] <= 1'b0;
        else if (ev[k])
          status_r[k] <= 1'b1;
        else if (wr_en && PADDR == `OFS_IRQ_CLR && PWDATA[k])
          status_r[k] <= 1'b0;
      end
    end
  endgenerate
  assign IRQ = |(status_r & irq_en_r);

  dma_bus_mover u_mover (
    .clk(CLK),
    .rst(RST),
    .start(start),
    .byte_mode(byte_mode),
    .ram_to_periph(dir_r2p),
    .null_write(null_write_mode),
    .ram_addr(ram_addr),
    .per_addr(per_addr_r),
    .bus_req(BUS_REQ),
    .bus_we(BUS_WE),
    .bus_byte(BUS_BYTE),
    .bus_addr(BUS_ADDR),
    .bus_wdata(BUS_WDATA),
    .bus_rdata(BUS_RDATA),
    .bus_ack(BUS_ACK),
    .done(mover_done)
  );
endmodule // dma_channel_control

// *** dv/dma_channel_control_sva.sv ***
// port-level assertions for the dma channel control block
`timescale 1ns/1ps
module dma_channel_control_sva (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PSLVERR,
  input wire logic BUS_REQ,
  input wire logic BUS_WE,
  input wire logic BUS_BYTE,
  input wire logic [15:0] BUS_ADDR,
  input wire logic [15:0] BUS_WDATA,
  input wire logic BUS_ACK,
  input wire logic IRQ
);
  logic [15:0] ctl_r;
  logic [15:0] per_r;
  // shadow of what software wrote; hardware clearing of enable is not mirrored
  always_ff @(posedge CLK)
  begin
    if (RST) ctl_r <= 16'h0000;
    else if (PSEL && PENABLE && PWRITE && PADDR == 12'h000) ctl_r <= PWDATA[15:0] & 16'hF833;
    if (RST) per_r <= 16'h0000;
    else if (PSEL && PENABLE && PWRITE && PADDR == 12'h00C) per_r <= PWDATA[15:0];
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  a_reset_quiet: assert property ($fell(RST) |-> !IRQ && !BUS_REQ)
    else $error("activity straight after reset");
  a_unmapped_err: assert property (PSEL && PENABLE && PADDR > 12'h020 |-> PSLVERR)
    else $error("unmapped access not refused");
  a_req_held: assert property (BUS_REQ && !BUS_ACK
    |=> BUS_REQ && $stable(BUS_ADDR) && $stable(BUS_WE))
    else $error("bus request dropped before ack");
  a_disabled_idle: assert property (!ctl_r[15] && !BUS_REQ |=> !BUS_REQ)
    else $error("move started while disabled");
  a_byte_size: assert property (BUS_REQ |-> BUS_BYTE == ctl_r[14])
    else $error("transfer size wrong");
  a_ram_to_per: assert property (BUS_REQ && BUS_WE && ctl_r[13] |-> BUS_ADDR == per_r)
    else $error("write not aimed at peripheral");
  a_per_to_ram: assert property (BUS_REQ && !BUS_WE && !ctl_r[13] |-> BUS_ADDR == per_r)
    else $error("read not taken from peripheral");
  a_null_zero: assert property (BUS_REQ && BUS_WE && ctl_r[11] && !ctl_r[13] && BUS_ADDR == per_r
    |-> BUS_WDATA == 16'h0000)
    else $error("null write carries data");
  c_irq: cover property ($rose(IRQ));
  c_null: cover property (BUS_REQ && BUS_WE && BUS_ACK && ctl_r[11]);
  c_refused: cover property (PSLVERR);
endmodule // dma_channel_control_sva
bind dma_channel_control dma_channel_control_sva i_sva (
  .CLK(CLK),
  .RST(RST),
  .PSEL(PSEL),
  .PENABLE(PENABLE),
  .PWRITE(PWRITE),
  .PADDR(PADDR),
  .PWDATA(PWDATA),
  .PSLVERR(PSLVERR),
  .BUS_REQ(BUS_REQ),
  .BUS_WE(BUS_WE),
  .BUS_BYTE(BUS_BYTE),
  .BUS_ADDR(BUS_ADDR),
  .BUS_WDATA(BUS_WDATA),
  .BUS_ACK(BUS_ACK),
  .IRQ(IRQ)
);

// *** dv/bus_partner.sv ***
// far-side model: ram and peripherals answering the channel's bus
`timescale 1ns/1ps
module bus_partner (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic req,
  input wire logic [15:0] addr,
  output logic [15:0] rdata,
  output logic ack
);
  logic [1:0] wait_r;
  wire logic hit = req && !ack && (!slow || wait_r == 2'h2);
  // one-cycle ack, stalled when slow; data toggles outside ack so stale values never match
  always_ff @(posedge clk)
  begin
    wait_r <= (rst || !req || ack) ? 2'h0 : wait_r + 2'h1;
    ack <= !rst && hit;
    rdata <= rst ? 16'h0000 : hit ? addr ^ 16'h5A5A : ~rdata;
  end
endmodule // bus_partner

// *** dv/testbench.sv ***
// self-checking bench for the dma channel control block
`timescale 1ns/1ps
module testbench;
  logic clk, rst, psel, penable, pwrite, preq, slow, pready, pslverr, breq, bwe, bbyte, back, irq;
  logic bsz, soft_t;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] baddr, bwdata, brdata, ra, rb, pa;
  logic [31:0] rq[$], wq[$];
  int bad_count, comparisons, i;
  dma_channel_control i_dma_channel_control (.CLK(clk), .RST(rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PERIPH_REQ(preq), .BUS_REQ(breq), .BUS_WE(bwe),
    .BUS_BYTE(bbyte), .BUS_ADDR(baddr), .BUS_WDATA(bwdata), .BUS_RDATA(brdata),
    .BUS_ACK(back), .IRQ(irq));
  bus_partner i_bus_partner (.clk(clk), .rst(rst), .slow(slow), .req(breq), .addr(baddr),
    .rdata(brdata), .ack(back));
  // 40 MHz
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task tmo;
    bad_count++;
    $display("Error at %0t: timeout", $time);
    finish_test();
  endtask
  // results are compared as they appear: apb read data and each bus write
  always @(posedge clk)
  begin
    if (psel && penable && pready && !pwrite)
      chk(prdata, rq.size() ? rq.pop_front() : 32'hDEADBEEF);
    if (breq && bwe && back)
      chk({baddr, bwdata}, wq.size() ? wq.pop_front() : 32'hDEADBEEF);
  end
  // apb master: hold the request until pready is seen, then one idle cycle
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    for (i = 0; pready !== 1'b1; i++)
    begin
      if (i == 20) tmo();
      @(posedge clk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0000, d});
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h00000000);
  endtask
  // element request, alternating between the request pin and the software trigger
  task poke;
    soft_t = !soft_t;
    if (soft_t)
      wr(12'h020, 16'h0001);
    else
    begin
      preq <= 1'b1;
      @(posedge clk);
      preq <= 1'b0;
    end
    repeat (10) @(posedge clk);
  endtask
  // one element move; expected writes are queued before the request goes out
  task xfer(input logic [15:0] r, input logic dir, input logic nw);
    logic [15:0] d;
    d = dir ? r ^ 16'h5A5A : pa ^ 16'h5A5A;
    if (bsz)
      d[15:8] = 8'h00; // byte moves carry only the low byte
    wq.push_back(dir ? {pa, d} : {r, d});
    if (nw) wq.push_back({pa, 16'h0000});
    poke();
    for (i = 0; wq.size() > 0; i++)
    begin
      if (i == 200) tmo();
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
  endtask
  task rst_dut(input int n);
    rst <= 1'b1;
    repeat (n) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask
  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite, preq} = 4'h0;
    {bsz, soft_t} = 2'b00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    void'($urandom(32'hD262A8EB));
    ra = {4'h1, 8'($urandom), 4'h0};
    rb = {4'h3, 8'($urandom), 4'h0};
    pa = {8'h80, 7'($urandom), 1'b0};
    slow = 1'($urandom);
    rst_dut(16);
    rd(12'h014, 0);
    wr(12'h024, 16'hFFFF);
    rd(12'h024, 0);
    wr(12'h000, 16'hFFFF);
    rd(12'h000, 32'h0000F833);
    $display("test 1 done");
    wr(12'h004, ra);
    wr(12'h00C, pa);
    wr(12'h010, 16'h0001);
    wr(12'h018, 16'h0001);
    wr(12'h000, 16'h9000);
    xfer(ra, 0, 0);
    chk(irq, 1);
    wr(12'h018, 0);
    chk(irq, 0);
    wr(12'h018, 1);
    wr(12'h01C, 7);
    chk(irq, 0);
    xfer(ra + 2, 0, 0);
    wr(12'h000, 0);
    poke();
    $display("test 2 done");
    wr(12'h01C, 7);
    wr(12'h000, 16'hC000);
    bsz = 1'b1;
    xfer(ra, 0, 0);
    chk(irq, 0);
    xfer(ra + 1, 0, 0);
    chk(irq, 1);
    $display("test 3 done");
    bsz = 1'b0;
    wr(12'h000, 16'h8800);
    xfer(ra, 0, 1);
    xfer(ra + 2, 0, 1);
    $display("test 4 done");
    wr(12'h000, 16'hA011);
    xfer(ra, 1, 0);
    xfer(ra, 1, 0);
    rd(12'h000, 32'h00002011);
    poke();
    $display("test 5 done");
    wr(12'h008, rb);
    wr(12'h010, 0);
    wr(12'h000, 16'h8003);
    xfer(ra, 0, 0);
    xfer(rb, 0, 0);
    rd(12'h000, 32'h00000003);
    rd(12'h014, 32'h00000007);
    poke();
    $display("test 6 done");
    rst_dut(2);
    wr(12'h004, ra);
    wr(12'h008, rb);
    wr(12'h00C, pa);
    wr(12'h000, 16'h8022);
    xfer(ra + pa, 0, 0);
    xfer(rb + pa, 0, 0);
    xfer(ra + pa, 0, 0);
    $display("test 7 done");
    finish_test();
  end
endmodule // testbench
